// *** bench/hpp_regs_monitor.sv ***
`timescale 1ns/1ps
module hpp_regs_monitor #(
  parameter int NPORT = 2
)(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  input wire logic [7:1]       port_power_pad_pullup,
  input wire logic [NPORT:1]   port_shared_pin,
  input wire logic [NPORT:1]   port_disabled,
  input wire logic [NPORT:1]   fixed_attached_device
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_pullup_write: assert property (!$stable(port_power_pad_pullup) |-> $rose(s_axi_bvalid))
    else $error("pull-up changed without write");
  a_status_write: assert property (!$stable({port_shared_pin, port_disabled, fixed_attached_device})
    |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2)) else $error("status changed without write");
endmodule

// *** bench/hpp_regs_tb.sv ***
`timescale 1ns/1ps
module hpp_regs_tb;
  import hpp_pkg::*;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:1]        usb2_port_power, usb3_port_power, general_purpose_pad, port_power_enable;
  logic [2:1]        port_shared_pin, port_disabled, fixed_attached_device;
  logic [7:1]        port_power_pad_pullup;
  int                bad_count, checks_done;
  hpp_regs #(.NPORT(2)) DUT (.*);
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 20 && !s_axi_bvalid; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 20) bad_count++;
    if (n == 20) finish_test();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 20 && !s_axi_rvalid; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    if (n == 20) bad_count++;
    if (n == 20) finish_test();
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic wchk(input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [31:0] e);
    wr(a, v);
    chk(r, RESP_OKAY);
    rd(a);
    chk(d, e);
  endtask
  task automatic t_reset();
    rd(PULLUP_ADDR);
    chk(d, PULLUP_RST);
    chk(r, RESP_OKAY);
    rd(SEL2_ADDR);
    chk(d, SEL_RST);
    chk(r, RESP_OKAY);
  endtask
  task automatic t_pullup();
    wchk(PULLUP_ADDR, 32'hffffffff, 32'h000000fe);
    chk(port_power_pad_pullup, 7'h7f);
    wchk(PULLUP_ADDR, 32'h00000055, 32'h00000054);
    chk(port_power_pad_pullup, 7'h2a);
  endtask
  task automatic t_sel();
    wchk(SEL1_ADDR, 32'h000000ff, 32'h000000bf);
    chk({port_shared_pin, port_disabled, fixed_attached_device}, 6'h15);
    wchk(SEL2_ADDR, 32'h00000090, 32'h00000090);
    chk({port_shared_pin, port_disabled, fixed_attached_device}, 6'h37);
    rd(SEL1_ADDR);
    chk(d, 32'h000000bf);
  endtask
  task automatic t_source();
    logic e;
    for (int c = 0; c < 8; c++) begin
      wr(SEL1_ADDR, c);
      for (int v = 0; v < 8; v++) begin
        @(posedge aclk);
        {usb2_port_power, usb3_port_power, general_purpose_pad} <= {{2{v[0]}}, {2{v[1]}}, {2{v[2]}}};
        repeat (4) @(posedge aclk);
        e = (c == 1) ? v[0] : (c == 2) ? v[1] : (c == 3) ? v[0] | v[1] : (c == 4) ? v[2] : 1'b0;
        chk(port_power_enable, {1'b0, e});
      end
    end
    wr(SEL2_ADDR, 32'h00000093);
    repeat (2) @(posedge aclk);
    chk(port_power_enable, 2'b10);
  endtask
  task automatic t_unmapped();
    wr(18'h00010, 32'h000000ff);
    chk(r, RESP_SLVERR);
    rd(18'h00010);
    chk(d, 32'h00000000);
    chk(r, RESP_SLVERR);
  endtask
  task automatic t_stall();
    int n;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid} <= {SEL2_ADDR, 1'b1};
    {s_axi_awaddr, s_axi_wdata} <= {PULLUP_ADDR, 32'h00000080};
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    for (n = 0; n < 20 && !(s_axi_rvalid && s_axi_bvalid); n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (n == 20) bad_count++;
    if (n == 20) finish_test();
    repeat (3) @(posedge aclk);
    {s_axi_bready, s_axi_rready} <= 2'b11;
    @(posedge aclk);
    {d, r} = {s_axi_rdata, s_axi_bresp};
    {s_axi_bready, s_axi_rready} <= 2'b00;
    chk(d, 32'h00000093);
    chk(r, RESP_OKAY);
    chk(port_power_pad_pullup, 7'h40);
  endtask
  task automatic t_strobe();
    s_axi_wstrb <= 4'h0;
    wr(PULLUP_ADDR, 32'h00000002);
    chk(r, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(PULLUP_ADDR);
    chk(d, 32'h00000080);
    chk(port_power_pad_pullup, 7'h40);
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    {bad_count, checks_done} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {usb2_port_power, usb3_port_power, general_purpose_pad} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pullup();
    t_sel();
    t_source();
    t_unmapped();
    t_stall();
    t_strobe();
    finish_test();
  end
endmodule
bind hpp_regs hpp_regs_monitor #(.NPORT(NPORT)) u_mon (.*);

// *** hdl/hpp_pkg.sv ***
package hpp_pkg;
  // register indices, byte address is four times the index
  localparam logic [15:0] PULLUP_IDX  = 16'h093e;
  localparam logic [15:0] SEL1_IDX    = 16'h3c00;
  localparam logic [15:0] SEL2_IDX    = 16'h3c04;
  localparam int          ADDR_W      = 18;
  localparam logic [ADDR_W-1:0] PULLUP_ADDR = {PULLUP_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] SEL1_ADDR   = {SEL1_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] SEL2_ADDR   = {SEL2_IDX, 2'b00};

  // field layout
  localparam logic [7:0] PULLUP_MASK   = 8'hfe;
  localparam logic [7:0] SEL_MASK      = 8'hbf;
  localparam int         SEL_SHARED    = 7;
  localparam int         SEL_DISABLED  = 5;
  localparam int         SEL_FIXED     = 4;
  localparam int         SRC_HI        = 3;

  // reset values
  localparam logic [7:0] PULLUP_RST    = 8'h00;
  localparam logic [7:0] SEL_RST       = 8'h00;

  // power source codes
  localparam logic [3:0] SRC_OFF       = 4'h0;
  localparam logic [3:0] SRC_USB2      = 4'h1;
  localparam logic [3:0] SRC_USB3      = 4'h2;
  localparam logic [3:0] SRC_EITHER    = 4'h3;
  localparam logic [3:0] SRC_GPIO      = 4'h4;

  localparam logic [1:0] RESP_OKAY     = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;
endpackage

// *** hdl/hpp_port_power_sel.sv ***
`timescale 1ns/1ps
module hpp_port_power_sel
  import hpp_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] source_code,
  input  wire logic       usb2_power,
  input  wire logic       usb3_power,
  input  wire logic       gpio_power,
  output logic            power_on
);
  import hpp_pkg::*;

  logic power_d;
  logic power_q;

  always_comb begin
    unique case (source_code)
      SRC_OFF:    power_d = 1'b0;
      SRC_USB2:   power_d = usb2_power;
      SRC_USB3:   power_d = usb3_power;
      SRC_EITHER: power_d = usb2_power | usb3_power;
      SRC_GPIO:   power_d = gpio_power;
      default:    power_d = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_q <= 1'b0;
    end else begin
      power_q <= power_d;
    end
  end

  assign power_on = power_q;
endmodule

// *** hdl/hpp_regs.sv ***
// Notes on behaviour
// - pull-up register bits 7 to 1 each switch the pull-up of one port power pad, one meaning on.
// - pull-up bit N drives the pull-up of pad N.
// - select bit 7 set means power and over-current sense share one pin, clear means separate pins.
// - select bit 5 set reports the port to the hub as permanently disabled.
// - select bit 4 set marks the port as having a fixed attached device.
// - the source field picks off, usb2 power, usb3 power, either, or the designated gpio.
// - ports 1 and 2 each have their own identical select register, at word indices four apart (0x3c00 and 0x3c04).
`timescale 1ns/1ps
module hpp_regs
  import hpp_pkg::*;
#(
  parameter int NPORT = 2
)(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [hpp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [hpp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [NPORT:1]           usb2_port_power,
  input  wire logic [NPORT:1]           usb3_port_power,
  input  wire logic [NPORT:1]           general_purpose_pad,
  output logic [7:1]                    port_power_pad_pullup,
  output logic [NPORT:1]                port_power_enable,
  output logic [NPORT:1]                port_shared_pin,
  output logic [NPORT:1]                port_disabled,
  output logic [NPORT:1]                fixed_attached_device
);
  import hpp_pkg::*;

  // register state
  logic [7:0]        pullup_q, pullup_d;
  logic [7:0]        sel_q [1:NPORT];
  logic [7:0]        sel_d [1:NPORT];
  logic [NPORT:1]    shared_q, shared_d;
  logic [NPORT:1]    disabled_q, disabled_d;
  logic [NPORT:1]    fixed_q, fixed_d;

  // write channel state
  logic              aw_held_q, aw_held_d;
  logic              w_held_q, w_held_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [7:0]        wbyte_q, wbyte_d;
  logic              wen_q, wen_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              awready_q, awready_d;
  logic              wready_q, wready_d;

  // read channel state
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic              arready_q, arready_d;

  // gpio pad synchroniser
  logic [NPORT:1]    gpio_meta_q;
  logic [NPORT:1]    gpio_sync_q;

  logic              do_write;
  logic              write_hit;
  logic [7:0]        read_byte;
  logic              read_hit;

  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    waddr_d   = waddr_q;
    wbyte_d   = wbyte_q;
    wen_d     = wen_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    write_hit = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      waddr_d   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wbyte_d  = s_axi_wdata[7:0];
      wen_d    = s_axi_wstrb[0];
    end
    if (do_write) begin
      write_hit = (waddr_q == PULLUP_ADDR) || (waddr_q == SEL1_ADDR) || (waddr_q == SEL2_ADDR);
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = write_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d  = 1'b0;
    end
    // readies registered so the bus outputs come from flops
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
  end

  // register updates on a completed write
  always_comb begin
    pullup_d = pullup_q;
    for (int p = 1; p <= NPORT; p++) begin
      sel_d[p] = sel_q[p];
    end
    if (do_write && wen_q) begin
      if (waddr_q == PULLUP_ADDR) begin
        pullup_d = wbyte_q & PULLUP_MASK;
      end
      if (waddr_q == SEL1_ADDR) begin
        sel_d[1] = wbyte_q & SEL_MASK;
      end
      if (waddr_q == SEL2_ADDR) begin
        sel_d[2] = wbyte_q & SEL_MASK;
      end
    end
  end

  // read path
  always_comb begin
    read_byte = 8'h00;
    read_hit  = 1'b1;
    if (s_axi_araddr == PULLUP_ADDR) begin
      read_byte = pullup_q;
    end else if (s_axi_araddr == SEL1_ADDR) begin
      read_byte = sel_q[1];
    end else if (s_axi_araddr == SEL2_ADDR) begin
      read_byte = sel_q[2];
    end else begin
      read_hit = 1'b0;
    end
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h000000, read_byte};
      rresp_d  = read_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // per-port status decode
  always_comb begin
    for (int p = 1; p <= NPORT; p++) begin
      shared_d[p]   = sel_q[p][SEL_SHARED];
      disabled_d[p] = sel_q[p][SEL_DISABLED];
      fixed_d[p]    = sel_q[p][SEL_FIXED];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pullup_q    <= PULLUP_RST;
      for (int p = 1; p <= NPORT; p++) begin
        sel_q[p] <= SEL_RST;
      end
      shared_q    <= '0;
      disabled_q  <= '0;
      fixed_q     <= '0;
      aw_held_q   <= 1'b0;
      w_held_q    <= 1'b0;
      waddr_q     <= '0;
      wbyte_q     <= 8'h00;
      wen_q       <= 1'b0;
      bvalid_q    <= 1'b0;
      bresp_q     <= RESP_OKAY;
      rvalid_q    <= 1'b0;
      rdata_q     <= 32'h00000000;
      rresp_q     <= RESP_OKAY;
      awready_q   <= 1'b1;
      wready_q    <= 1'b1;
      arready_q   <= 1'b1;
      gpio_meta_q <= '0;
      gpio_sync_q <= '0;
    end else begin
      pullup_q    <= pullup_d;
      for (int p = 1; p <= NPORT; p++) begin
        sel_q[p] <= sel_d[p];
      end
      shared_q    <= shared_d;
      disabled_q  <= disabled_d;
      fixed_q     <= fixed_d;
      aw_held_q   <= aw_held_d;
      w_held_q    <= w_held_d;
      waddr_q     <= waddr_d;
      wbyte_q     <= wbyte_d;
      wen_q       <= wen_d;
      bvalid_q    <= bvalid_d;
      bresp_q     <= bresp_d;
      rvalid_q    <= rvalid_d;
      rdata_q     <= rdata_d;
      rresp_q     <= rresp_d;
      awready_q   <= awready_d;
      wready_q    <= wready_d;
      arready_q   <= arready_d;
      gpio_meta_q <= general_purpose_pad;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // source selection per port
  generate
    for (genvar g = 1; g <= NPORT; g++) begin : g_port
      hpp_port_power_sel u_sel (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .source_code (sel_q[g][SRC_HI:0]),
        .usb2_power  (usb2_port_power[g]),
        .usb3_power  (usb3_port_power[g]),
        .gpio_power  (gpio_sync_q[g]),
        .power_on    (port_power_enable[g])
      );
    end
  endgenerate

  assign s_axi_awready         = awready_q;
  assign s_axi_wready          = wready_q;
  assign s_axi_bvalid          = bvalid_q;
  assign s_axi_bresp           = bresp_q;
  assign s_axi_arready         = arready_q;
  assign s_axi_rvalid          = rvalid_q;
  assign s_axi_rdata           = rdata_q;
  assign s_axi_rresp           = rresp_q;
  assign port_power_pad_pullup = pullup_q[7:1];
  assign port_shared_pin       = shared_q;
  assign port_disabled         = disabled_q;
  assign fixed_attached_device = fixed_q;
endmodule
